// [common/lpddr_pins_pkg.sv]
// shared constants for the low-power ddr pin command link
package lpddr_pins_pkg;
  localparam int unsigned addr_w = 13;          // a0..a12
  localparam int unsigned bank_w = 2;           // two bank select inputs
  localparam int unsigned dq_w = 16;            // sixteen-bit organisation
  localparam int unsigned bank_n = 4;           // quad bank
  localparam int unsigned ap_bit = 10;          // auto precharge select bit
  localparam int unsigned burst_len = 4;        // words per burst
  localparam int unsigned col_w = 10;           // column bits used
  localparam int unsigned mem_words = 1024;     // small model array
  localparam int unsigned rd_lat = 2;           // read latency in clocks
  // command codes {ras_n,cas_n,we_n} with chip select low
  localparam logic [2:0] cmd_nop = 3'h7;
  localparam logic [2:0] cmd_act = 3'h3;
  localparam logic [2:0] cmd_rd = 3'h5;
  localparam logic [2:0] cmd_wr = 3'h4;
  localparam logic [2:0] cmd_bst = 3'h6;
  localparam logic [2:0] cmd_pre = 3'h2;
  localparam logic [2:0] cmd_ref = 3'h1;
  localparam logic [2:0] cmd_lmr = 3'h0;
  localparam logic [addr_w-1:0] mode_reset = 13'h0032; // mode word reset
endpackage : lpddr_pins_pkg

// [common/lpddr_link_if.sv]
// pin level link between controller and dram
`timescale 1ns/100ps
interface lpddr_link_if;
  logic cke;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [lpddr_pins_pkg::bank_w-1:0] bank_select_inputs;
  logic [lpddr_pins_pkg::addr_w-1:0] addr;
  // data words: each clock carries a rise word and a fall word
  logic [lpddr_pins_pkg::dq_w-1:0] dq_ctl_rise;
  logic [lpddr_pins_pkg::dq_w-1:0] dq_ctl_fall;
  logic dq_ctl_oe_n;
  logic [lpddr_pins_pkg::dq_w-1:0] dq_mem_rise;
  logic [lpddr_pins_pkg::dq_w-1:0] dq_mem_fall;
  logic dq_mem_oe_n;
  logic [1:0] upper_byte_write_mask;   // [0] rise word, [1] fall word
  logic [1:0] lower_byte_write_mask;
  logic dqs_ctl;       // strobe driven by controller on writes
  logic dqs_ctl_oe_n;
  logic dqs_mem;       // strobe driven by dram on reads
  logic dqs_mem_oe_n;
  modport ctl (output cke, cs_n, ras_n, cas_n, we_n, bank_select_inputs,
    addr, dq_ctl_rise, dq_ctl_fall, dq_ctl_oe_n, upper_byte_write_mask,
    lower_byte_write_mask, dqs_ctl, dqs_ctl_oe_n,
    input dq_mem_rise, dq_mem_fall, dq_mem_oe_n, dqs_mem, dqs_mem_oe_n);
  modport mem (input cke, cs_n, ras_n, cas_n, we_n, bank_select_inputs,
    addr, dq_ctl_rise, dq_ctl_fall, dq_ctl_oe_n, upper_byte_write_mask,
    lower_byte_write_mask, dqs_ctl, dqs_ctl_oe_n,
    output dq_mem_rise, dq_mem_fall, dq_mem_oe_n, dqs_mem, dqs_mem_oe_n);
endinterface : lpddr_link_if

// [core/lpddr_dram_end.sv]
// dram end: command decode, bank state, masked writes, read bursts
//
// What this block does
// RULE_01: control inputs captured on rising clock edge
// RULE_02: two data words per clock cycle
// RULE_03: cke low stops clocks, inputs, drivers; here it gates inputs and drivers while the burst counters keep running
// RULE_04: cke low picks power-down kind from banks
// RULE_05: cke synchronous except self refresh exit; here self refresh exit is also sampled on the clock edge
// RULE_06: power-down ignores every input except cke
// RULE_07: decoder acts only with chip select low
// RULE_08: command from cs ras cas we
// RULE_09: masked write words are not stored
// RULE_10: one mask value per data word
// RULE_11: lower mask bits 7:0, upper 15:8
// RULE_12: bank inputs select target bank
// RULE_13: row with active, column plus precharge flag
// RULE_14: precharge a10 low one bank, high all
// RULE_15: load mode takes thirteen address bits
// RULE_16: sixteen line bidirectional data bus
// RULE_17: dram drives strobe on reads only
// RULE_18: deselect leaves running bursts untouched
`timescale 1ns/100ps
module lpddr_dram_end #(
  parameter int unsigned depth = lpddr_pins_pkg::mem_words
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // link to controller
  lpddr_link_if.mem link,
  // status
  output logic [1:0] power_state_r,
  output logic [lpddr_pins_pkg::bank_n-1:0] bank_open_r,
  output logic [lpddr_pins_pkg::addr_w-1:0] mode_word_r
);
  // refuse an array that the column counters cannot address
  if (depth < 2 || depth > lpddr_pins_pkg::mem_words)
  begin : depth_check
    $error("depth out of range");
  end

  typedef enum logic [1:0]
  {
    pw_run = 2'b00,
    pw_pre_pd = 2'b01,
    pw_act_pd = 2'b10,
    pw_self_ref = 2'b11
  } pw_e;

  localparam int unsigned aw = $clog2(depth);
  logic [15:0] mem [depth];          // storage array
  pw_e pw_r;
  logic [2:0] cmd;                   // decoded command code
  logic sel;                         // chip selected and inputs live
  logic [aw-1:0] col;
  logic [15:0] row_r [lpddr_pins_pkg::bank_n];
  logic [2:0] wr_cnt_r;              // remaining write beats
  logic [aw-1:0] wr_col_r;
  logic [2:0] rd_cnt_r;              // remaining read beats
  logic [aw-1:0] rd_col_r;
  logic [lpddr_pins_pkg::rd_lat-1:0] rd_pipe_r;
  logic [aw-1:0] rd_start_r [lpddr_pins_pkg::rd_lat];
  logic [15:0] rise_r;
  logic [15:0] fall_r;
  logic drive_r;

  // inputs live only while running with cke high [RULE_03] [RULE_06]
  assign sel = link.cke && pw_r == pw_run && !link.cs_n; // [RULE_07]
  assign cmd = {link.ras_n, link.cas_n, link.we_n};      // [RULE_08]
  assign col = aw'(link.addr[lpddr_pins_pkg::col_w-1:0]);

  // power mode; self refresh leaves on cke high alone, no command needed
  always_ff @(posedge clk)
  begin
    if (!nrst)
      pw_r <= pw_run;
    else if (pw_r == pw_run && !link.cke)
    begin
      // entry kind follows bank state [RULE_04]; sel is already dead with
      // cke low, so refresh with cke low is decoded from the raw pins
      if (!link.cs_n && cmd == lpddr_pins_pkg::cmd_ref)
        pw_r <= pw_self_ref;
      else if (|bank_open_r)
        pw_r <= pw_act_pd;
      else
        pw_r <= pw_pre_pd;
    end
    else if (pw_r != pw_run && link.cke)
      pw_r <= pw_run;  // sampled each edge; exit is one clock [RULE_05]
  end
  always_ff @(posedge clk)
  begin
    if (!nrst)
      power_state_r <= 2'h0;
    else
      power_state_r <= pw_r;
  end

  // bank tracking for active and precharge [RULE_12] [RULE_14]
  always_ff @(posedge clk)
  begin
    if (!nrst)
      bank_open_r <= '0;
    else if (sel && cmd == lpddr_pins_pkg::cmd_act)
      bank_open_r[link.bank_select_inputs] <= 1'b1;
    else if (sel && cmd == lpddr_pins_pkg::cmd_pre)
    begin
      if (link.addr[lpddr_pins_pkg::ap_bit])
        bank_open_r <= '0;
      else
        bank_open_r[link.bank_select_inputs] <= 1'b0;
    end
    else if (sel && (cmd == lpddr_pins_pkg::cmd_rd ||
                     cmd == lpddr_pins_pkg::cmd_wr) &&
             link.addr[lpddr_pins_pkg::ap_bit])
      bank_open_r[link.bank_select_inputs] <= 1'b0; // [RULE_13]
  end

  // row latch per bank, row address rides with active [RULE_13]
  always_ff @(posedge clk)
  begin
    if (sel && cmd == lpddr_pins_pkg::cmd_act)
      row_r[link.bank_select_inputs] <= {3'h0, link.addr};
  end

  // mode register load, pins taken on the rising edge [RULE_01] [RULE_15]
  always_ff @(posedge clk)
  begin
    if (!nrst)
      mode_word_r <= lpddr_pins_pkg::mode_reset;
    else if (sel && cmd == lpddr_pins_pkg::cmd_lmr)
      mode_word_r <= link.addr;
  end

  // write burst: two words per clock, deselect does not stop it [RULE_18]
  always_ff @(posedge clk)
  begin
    if (!nrst)
      wr_cnt_r <= 3'h0;
    else if (sel && cmd == lpddr_pins_pkg::cmd_wr)
    begin
      wr_cnt_r <= 3'(lpddr_pins_pkg::burst_len / 2);
      wr_col_r <= col;
    end
    else if (sel && cmd == lpddr_pins_pkg::cmd_bst)
      wr_cnt_r <= 3'h0;
    else if (wr_cnt_r != 3'h0)
    begin
      wr_cnt_r <= wr_cnt_r - 3'h1;
      wr_col_r <= wr_col_r + aw'(2);
    end
  end

  // masked byte stores, one mask per word [RULE_09] [RULE_10] [RULE_11]
  always_ff @(posedge clk)
  begin
    if (wr_cnt_r != 3'h0 && link.cke)
    begin
      if (!link.lower_byte_write_mask[0])
        mem[wr_col_r][7:0] <= link.dq_ctl_rise[7:0];
      if (!link.upper_byte_write_mask[0])
        mem[wr_col_r][15:8] <= link.dq_ctl_rise[15:8];
      if (!link.lower_byte_write_mask[1])
        mem[wr_col_r + aw'(1)][7:0] <= link.dq_ctl_fall[7:0];
      if (!link.upper_byte_write_mask[1])
        mem[wr_col_r + aw'(1)][15:8] <= link.dq_ctl_fall[15:8]; // [RULE_02]
    end
  end

  // read latency pipe
  always_ff @(posedge clk)
  begin
    if (!nrst)
      rd_pipe_r <= '0;
    else
      rd_pipe_r <= {rd_pipe_r[lpddr_pins_pkg::rd_lat-2:0],
                    sel && cmd == lpddr_pins_pkg::cmd_rd};
  end
  always_ff @(posedge clk)
  begin
    rd_start_r[0] <= col;
    for (int i = 1; i < lpddr_pins_pkg::rd_lat; i++)
      rd_start_r[i] <= rd_start_r[i-1];
  end

  // read burst runs through deselects [RULE_18]
  always_ff @(posedge clk)
  begin
    if (!nrst)
      rd_cnt_r <= 3'h0;
    else if (rd_pipe_r[lpddr_pins_pkg::rd_lat-1])
    begin
      rd_cnt_r <= 3'(lpddr_pins_pkg::burst_len / 2);
      rd_col_r <= rd_start_r[lpddr_pins_pkg::rd_lat-1];
    end
    else if (sel && cmd == lpddr_pins_pkg::cmd_bst)
      rd_cnt_r <= 3'h0;
    else if (rd_cnt_r != 3'h0)
    begin
      rd_cnt_r <= rd_cnt_r - 3'h1;
      rd_col_r <= rd_col_r + aw'(2);
    end
  end

  // output words and strobe; drivers off when cke low [RULE_03] [RULE_17]
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      rise_r <= 16'h0000;
      fall_r <= 16'h0000;
      drive_r <= 1'b0;
    end
    else
    begin
      drive_r <= rd_cnt_r != 3'h0 && link.cke;
      rise_r <= mem[rd_col_r];
      fall_r <= mem[rd_col_r + aw'(1)]; // [RULE_02] [RULE_16]
    end
  end
  assign link.dq_mem_rise = rise_r;
  assign link.dq_mem_fall = fall_r;
  assign link.dq_mem_oe_n = !drive_r;
  assign link.dqs_mem = drive_r;   // edge aligned with data words
  assign link.dqs_mem_oe_n = !drive_r;
endmodule : lpddr_dram_end

// [core/lpddr_ctl_end.sv]
// controller end: turns user requests into pin commands and data beats
`timescale 1ns/100ps
module lpddr_ctl_end (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // user request
  input wire logic req_valid,
  output logic req_ready_r,
  input wire logic [2:0] req_cmd,
  input wire logic [1:0] req_bank,
  input wire logic [12:0] req_addr,
  input wire logic req_cke,
  input wire logic [31:0] req_wdata,
  input wire logic [3:0] req_wmask,
  // read data out through buffer
  output logic rd_valid_r,
  input wire logic rd_ready,
  output logic [31:0] rd_data_r,
  // link to dram
  lpddr_link_if.ctl link
);
  logic [2:0] cmd_r;
  logic [1:0] bank_r;
  logic [12:0] addr_r;
  logic cs_n_r;
  logic cke_r;
  logic [1:0] wbeat_r;
  logic [31:0] wdata_r;
  logic [3:0] wmask_r;
  logic [31:0] buf_r [2];   // two-entry read buffer
  logic [1:0] cnt_r;
  logic wp_r;
  logic rp_r;
  logic push;
  logic pop;
  logic [2:0] rd_wait_r;    // clocks until a taken read has landed

  // a request is taken only while the buffer can absorb a read burst
  assign push = !link.dq_mem_oe_n;
  assign pop = rd_valid_r && rd_ready;
  // ready drops at once on a read or write, else a second one slips in
  always_ff @(posedge clk)
  begin
    if (!nrst)
      req_ready_r <= 1'b0;
    else if (req_valid && req_ready_r &&
             (req_cmd == lpddr_pins_pkg::cmd_wr ||
              req_cmd == lpddr_pins_pkg::cmd_rd))
      req_ready_r <= 1'b0;
    else
      req_ready_r <= cnt_r == 2'h0 && wbeat_r == 2'h0 && rd_wait_r == 3'h0;
  end

  // a read burst is still in flight until its last word is pushed:
  // pin register, latency, burst counter, word register, two beats
  always_ff @(posedge clk)
  begin
    if (!nrst)
      rd_wait_r <= 3'h0;
    else if (req_valid && req_ready_r && req_cmd == lpddr_pins_pkg::cmd_rd)
      rd_wait_r <= 3'(lpddr_pins_pkg::rd_lat + 4);
    else if (rd_wait_r != 3'h0)
      rd_wait_r <= rd_wait_r - 3'h1;
  end

  // command pins launched on the rising edge [RULE_01] [RULE_08]
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      cs_n_r <= 1'b1;
      cmd_r <= lpddr_pins_pkg::cmd_nop;
      bank_r <= 2'h0;
      addr_r <= 13'h0000;
      cke_r <= 1'b1;
    end
    else
    begin
      cke_r <= req_cke;  // [RULE_04]
      cs_n_r <= !(req_valid && req_ready_r);
      cmd_r <= req_cmd;
      bank_r <= req_bank;  // [RULE_12]
      addr_r <= req_addr;  // [RULE_13] [RULE_14] [RULE_15]
    end
  end

  // write beat: one rise and one fall word per cycle [RULE_09] [RULE_10]
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      wbeat_r <= 2'h0;
      wdata_r <= 32'h0;
      wmask_r <= 4'hf;
    end
    else if (req_valid && req_ready_r && req_cmd == lpddr_pins_pkg::cmd_wr)
    begin
      wbeat_r <= 2'h3;  // first clock idle while the dram registers it
      wdata_r <= req_wdata;
      wmask_r <= req_wmask;
    end
    else if (wbeat_r != 2'h0)
      wbeat_r <= wbeat_r - 2'h1;
  end
  assign link.cke = cke_r;
  assign link.cs_n = cs_n_r;
  assign link.ras_n = cmd_r[2];
  assign link.cas_n = cmd_r[1];
  assign link.we_n = cmd_r[0];
  assign link.bank_select_inputs = bank_r;
  assign link.addr = addr_r;
  assign link.dq_ctl_rise = wdata_r[15:0];
  assign link.dq_ctl_fall = wdata_r[31:16];
  assign link.lower_byte_write_mask = {wmask_r[2], wmask_r[0]};
  assign link.upper_byte_write_mask = {wmask_r[3], wmask_r[1]};
  // data stands in the two clocks in which the dram stores it
  assign link.dq_ctl_oe_n = wbeat_r == 2'h0 || wbeat_r == 2'h3;
  assign link.dqs_ctl = wbeat_r == 2'h1 || wbeat_r == 2'h2; // [RULE_17]
  assign link.dqs_ctl_oe_n = wbeat_r == 2'h0 || wbeat_r == 2'h3;

  // read buffer fill and drain
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      cnt_r <= 2'h0;
      wp_r <= 1'b0;
      rp_r <= 1'b0;
    end
    else
    begin
      if (push && cnt_r != 2'h2)
      begin
        buf_r[wp_r] <= {link.dq_mem_fall, link.dq_mem_rise}; // [RULE_02]
        wp_r <= !wp_r;
      end
      if (pop)
        rp_r <= !rp_r;
      cnt_r <= cnt_r + 2'(push && cnt_r != 2'h2) - 2'(pop);
    end
  end
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      rd_valid_r <= 1'b0;
      rd_data_r <= 32'h0;
    end
    else
    begin
      rd_valid_r <= cnt_r - 2'(pop) != 2'h0;
      rd_data_r <= buf_r[rp_r ^ pop];
    end
  end
endmodule : lpddr_ctl_end

// [tb/lpddr_link_asserts.sv]
// checker on the pin link between the controller and dram ends
`timescale 1ns/100ps
module lpddr_link_asserts (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // command pins
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  // drive enables, low while driving
  input wire logic dq_ctl_oe_n,
  input wire logic dq_mem_oe_n,
  input wire logic dqs_ctl_oe_n,
  input wire logic dqs_mem_oe_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic [2:0] cmd; // command strobes as one code
  logic rd_taken; // read registered by the dram
  logic wr_taken; // write registered by the dram
  logic [3:0] since_rd_r; // cycles since last read, saturates
  assign cmd = {ras_n, cas_n, we_n};
  assign rd_taken = cke & ~cs_n & (cmd == lpddr_pins_pkg::cmd_rd);
  assign wr_taken = cke & ~cs_n & (cmd == lpddr_pins_pkg::cmd_wr);
  // age of the last read, so stray read drive is caught
  always_ff @(posedge clk)
  begin
    if (!nrst)
      since_rd_r <= 4'hf;
    else if (rd_taken)
      since_rd_r <= 4'h0;
    else if (since_rd_r != 4'hf)
      since_rd_r <= since_rd_r + 4'h1;
  end
  chk_bus_no_fight: assert property (dq_ctl_oe_n | dq_mem_oe_n)
    else $error("both ends drive the data bus");
  chk_dqs_no_fight: assert property (dqs_ctl_oe_n | dqs_mem_oe_n)
    else $error("both ends drive the strobe");
  chk_wr_strobe: assert property (!dq_ctl_oe_n |-> !dqs_ctl_oe_n)
    else $error("write data without controller strobe");
  chk_read_answer: assert property (rd_taken |->
    ##[2:4] !dq_mem_oe_n ##1 !dq_mem_oe_n)
    else $error("read burst not driven two clocks");
  chk_read_window: assert property (!dq_mem_oe_n |->
    since_rd_r inside {[1:5]})
    else $error("dram drives data without a read");
  chk_write_data: assert property (wr_taken |-> ##[1:2] !dq_ctl_oe_n)
    else $error("write data not driven");
  chk_reset_idle: assert property ($rose(nrst) |->
    cs_n && cke && dq_ctl_oe_n)
    else $error("controller not idle after reset");
  chk_pd_quiet: assert property ($past(!cke) && !cke |->
    dq_mem_oe_n && dqs_mem_oe_n)
    else $error("dram drives while clock disabled");
  cov_read: cover property (rd_taken);
  cov_write: cover property (wr_taken);
  cov_pd: cover property (!cke ##1 cke);
endmodule : lpddr_link_asserts

// [tb/lpddr_pin_command_interface_tb.sv]
// top bench: both ends joined, user side driven and checked
`timescale 1ns/100ps
module lpddr_pin_command_interface_tb;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  // user side stimulus
  logic req_valid = 1'b0, req_cke = 1'b1, rd_ready = 1'b1;
  logic [2:0] req_cmd = lpddr_pins_pkg::cmd_nop;
  logic [1:0] req_bank = 2'h0;
  logic [12:0] req_addr = 13'h0000;
  logic [31:0] req_wdata = 32'h0, d0, exp_w;
  logic [3:0] req_wmask = 4'h0;
  // design outputs
  logic req_ready_r, rd_valid_r;
  logic [31:0] rd_data_r;
  logic [1:0] power_state_r;
  logic [3:0] bank_open_r;
  logic [12:0] mode_word_r;
  int err_total = 0, checks_done = 0, cycles = 0, seed = 3;
  logic [31:0] exp_q[$]; // read words still owed
  lpddr_link_if link();
  lpddr_ctl_end lpddr_ctl_end_i (.clk(clk), .nrst(nrst),
    .req_valid(req_valid), .req_ready_r(req_ready_r), .req_cmd(req_cmd),
    .req_bank(req_bank), .req_addr(req_addr), .req_cke(req_cke),
    .req_wdata(req_wdata), .req_wmask(req_wmask), .rd_valid_r(rd_valid_r),
    .rd_ready(rd_ready), .rd_data_r(rd_data_r), .link(link));
  lpddr_dram_end lpddr_dram_end_i (.clk(clk), .nrst(nrst), .link(link),
    .power_state_r(power_state_r), .bank_open_r(bank_open_r),
    .mode_word_r(mode_word_r));
  lpddr_link_asserts lpddr_link_asserts_i (.clk(clk), .nrst(nrst),
    .cke(link.cke), .cs_n(link.cs_n), .ras_n(link.ras_n),
    .cas_n(link.cas_n), .we_n(link.we_n), .dq_ctl_oe_n(link.dq_ctl_oe_n),
    .dq_mem_oe_n(link.dq_mem_oe_n), .dqs_ctl_oe_n(link.dqs_ctl_oe_n),
    .dqs_mem_oe_n(link.dqs_mem_oe_n));
  initial
  begin
    forever #4 clk = ~clk;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("errors %0d checks %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  // one request; valid stays up so back to back requests never glitch
  task automatic send(input logic [2:0] c, input logic [1:0] b,
    input logic [12:0] a, input logic k);
    int n;
    n = 0;
    req_cmd = c;
    req_bank = b;
    req_addr = a;
    req_cke = k;
    req_valid = 1'b1;
    @(posedge clk);
    while (req_ready_r !== 1'b1 && n < 200)
    begin
      n++;
      @(posedge clk);
    end
    #1;
  endtask : send
  // drop valid and let status settle before comparing it
  task automatic rest(input logic [5:0] exp_st);
    req_valid = 1'b0;
    repeat (6) @(posedge clk);
    #1;
    check({26'h0, power_state_r, bank_open_r}, {26'h0, exp_st});
  endtask : rest
  // hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_total++;
      tally_and_finish();
    end
  end
  // receiver stalls at random so the read buffer must hold words
  always @(posedge clk)
    #1 rd_ready = 1'($random(seed));
  // read monitor pops the oldest owed word per accepted beat
  always @(posedge clk)
    if (rd_valid_r === 1'b1 && rd_ready === 1'b1)
    begin
      if (exp_q.size() == 0)
      begin
        checks_done++;
        err_total++;
        $display("FAIL %0t read word with none owed", $time);
      end
      else
        check(rd_data_r, exp_q.pop_front());
    end
  initial
  begin
    repeat (16) @(posedge clk);
    #1 nrst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check({19'h0, mode_word_r}, 32'h0032);
    rest(6'h00);
    req_addr = 13'($random(seed));
    send(lpddr_pins_pkg::cmd_lmr, 2'h0, req_addr, 1'b1);
    rest(6'h00);
    check({19'h0, mode_word_r}, {19'h0, req_addr});
    for (int b = 0; b < 4; b++)
      send(lpddr_pins_pkg::cmd_act, b[1:0], 13'h0100, 1'b1);
    rest(6'h0f);
    // full write, masked overwrite, then read back every bank
    for (int b = 0; b < 4; b++)
    begin
      d0 = $random(seed);
      req_wdata = d0;
      req_wmask = 4'h0;
      send(lpddr_pins_pkg::cmd_wr, b[1:0], 13'(16 * b), 1'b1);
      req_wdata = $random(seed);
      req_wmask = 4'($random(seed));
      send(lpddr_pins_pkg::cmd_wr, b[1:0], 13'(16 * b), 1'b1);
      for (int i = 0; i < 4; i++)
        exp_w[8*i+:8] = req_wmask[i] ? d0[8*i+:8] : req_wdata[8*i+:8];
      exp_q.push_back(exp_w);
      exp_q.push_back(exp_w);
      send(lpddr_pins_pkg::cmd_rd, b[1:0],
        13'(16 * b) | (b == 0 ? 13'h0400 : 13'h0000), 1'b1);
    end
    rest(6'h0e);
    send(lpddr_pins_pkg::cmd_pre, 2'h1, 13'h0000, 1'b1);
    rest(6'h0c);
    send(lpddr_pins_pkg::cmd_pre, 2'h0, 13'h0400, 1'b1);
    rest(6'h00);
    send(lpddr_pins_pkg::cmd_act, 2'h2, 13'h0000, 1'b1);
    send(lpddr_pins_pkg::cmd_nop, 2'h0, 13'h0000, 1'b0);
    rest(6'h24);
    send(lpddr_pins_pkg::cmd_act, 2'h3, 13'h0000, 1'b0);
    rest(6'h24);
    send(lpddr_pins_pkg::cmd_nop, 2'h0, 13'h0000, 1'b1);
    rest(6'h04);
    send(lpddr_pins_pkg::cmd_pre, 2'h0, 13'h0400, 1'b1);
    send(lpddr_pins_pkg::cmd_nop, 2'h0, 13'h0000, 1'b0);
    rest(6'h10);
    send(lpddr_pins_pkg::cmd_nop, 2'h0, 13'h0000, 1'b1);
    send(lpddr_pins_pkg::cmd_ref, 2'h0, 13'h0000, 1'b0);
    rest(6'h30);
    send(lpddr_pins_pkg::cmd_nop, 2'h0, 13'h0000, 1'b1);
    rest(6'h00);
    check(exp_q.size(), 32'h0);
    tally_and_finish();
  end
endmodule : lpddr_pin_command_interface_tb
